/* File: sac_pkg.sv */
// Constants, register map and types of the converter control block
`default_nettype none
package sac_pkg;
    // Register byte offsets
    localparam logic [11:0] SAC_OFF_CTRL0    = 12'h000;
    localparam logic [11:0] SAC_OFF_CTRL1    = 12'h004;
    localparam logic [11:0] SAC_OFF_IRQ_STAT = 12'h008;
    localparam logic [11:0] SAC_OFF_IRQ_MASK = 12'h00C;
    localparam logic [11:0] SAC_OFF_STATE    = 12'h010;
    localparam logic [11:0] SAC_OFF_RES_LO   = 12'h020;
    localparam logic [11:0] SAC_OFF_RES_END  = 12'h060;
    // Control word 0 fields
    localparam int SAC_CH_LSB    = 0;
    localparam int SAC_MODE_LSB  = 3;
    localparam int SAC_START_BIT = 6;
    localparam int SAC_EXT_BIT   = 7;
    localparam int SAC_DIV_LSB   = 8;
    // Control word 1 fields
    localparam int SAC_SH_BIT    = 0;
    localparam int SAC_RES10_BIT = 1;
    localparam int SAC_SWEEP_LSB = 2;
    localparam int SAC_VREF_BIT  = 5;
    // Result register layout: channel in offset bits 5:3, high part at bit 2
    localparam int SAC_RES_CH_LSB = 3;
    localparam int SAC_RES_HI_BIT = 2;
    // Interrupt status bits
    localparam int SAC_IRQ_ONESHOT = 0;
    localparam int SAC_IRQ_SWEEP   = 1;
    localparam int SAC_IRQ_W       = 2;
    // Operating modes
    localparam logic [2:0] SAC_MODE_ONESHOT = 3'h0;
    localparam logic [2:0] SAC_MODE_REPEAT  = 3'h1;
    localparam logic [2:0] SAC_MODE_SWEEP   = 3'h2;
    localparam logic [2:0] SAC_MODE_RSWEEP0 = 3'h3;
    localparam logic [2:0] SAC_MODE_RSWEEP1 = 3'h4;
    // Conversion clock divider selects
    localparam logic [1:0] SAC_DIV_1 = 2'h0;
    localparam logic [1:0] SAC_DIV_2 = 2'h1;
    // Conversion lengths in conversion clock cycles, trial bit counts and result widths
    localparam logic [5:0] SAC_CYC_8     = 6'd49;
    localparam logic [5:0] SAC_CYC_10    = 6'd59;
    localparam logic [5:0] SAC_CYC_SH_8  = 6'd28;
    localparam logic [5:0] SAC_CYC_SH_10 = 6'd33;
    localparam logic [5:0] SAC_BITS_8    = 6'd8;
    localparam logic [5:0] SAC_BITS_10   = 6'd10;
    localparam int         SAC_RES_W     = 10;
    localparam int         SAC_LO_W      = 8;

    typedef enum logic [1:0] {
        SAC_IDLE = 2'b01,
        SAC_CONV = 2'b10
    } sac_state_t;
endpackage
`default_nettype wire

/* File: sac_result_mem.sv */
// Result store, one word per channel with separate low and high write enables
`default_nettype none
module sac_result_mem #(
    parameter int DEPTH = 8,
    parameter int WIDTH = 10,
    parameter int LO_W  = 8,
    parameter int AW    = 3
) (
    // Clock and reset
    input  wire logic             clk_i,
    input  wire logic             rst_n_i,
    // Write port
    input  wire logic             we_lo_i,
    input  wire logic             we_hi_i,
    input  wire logic [AW-1:0]    waddr_i,
    input  wire logic [WIDTH-1:0] wdata_i,
    // Read port
    input  wire logic [AW-1:0]    raddr_i,
    output logic      [WIDTH-1:0] rdata_o
);
    logic [WIDTH-1:0] mem [DEPTH];

    for (genvar i = 0; i < DEPTH; i++) begin : g_entry
        always_ff @(posedge clk_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
                mem[i] <= '0;
            end else if (waddr_i == AW'(i)) begin
                if (we_lo_i) begin
                    mem[i][LO_W-1:0] <= wdata_i[LO_W-1:0];
                end
                if (we_hi_i) begin
                    mem[i][WIDTH-1:LO_W] <= wdata_i[WIDTH-1:LO_W];
                end
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_o <= '0;
        end else begin
            rdata_o <= mem[raddr_i];
        end
    end
endmodule
`default_nettype wire

/* File: sac_top.sv */
// Successive-approximation converter control with APB registers
`default_nettype none
// Summary of operation
// - Results go per channel: low byte at even word, top two bits odd.
// - Resolution selectable as 8 or 10 bits.
// - Conversion clock is system clock undivided, halved or quartered.
// - Five modes: one-shot, repeat, single sweep, repeat sweeps 0 and 1.
// - Software trigger: conversion starts when start flag goes 0 to 1.
// - External trigger: falling edge with start flag set starts or retriggers.
// - Without sample-hold: 49 cycles at 8 bits, 59 at 10 bits.
// - With sample-hold: 28 cycles at 8 bits, 33 at 10 bits.
// - One-shot converts exactly once on the selected channel.
// - One-shot end clears start unless external trigger; writing 0 stops.
// - One-shot completion raises the interrupt.
// - Sample-hold enabled by bit 0 of control word 1, all modes.
module sac_top
    import sac_pkg::*;
#(
    parameter int NCH = 8
) (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    // APB slave
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [11:0] paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    // Interrupt
    output logic             irq_o,
    // Analog front end
    input  wire logic        external_trigger_input_i,
    input  wire logic        comp_i,
    output logic      [2:0]  analog_channels_o,
    output logic      [9:0]  sar_code_o,
    output logic             sample_o,
    output logic             busy_o,
    output logic             vref_connect_o
);
    sac_state_t state;
    logic [2:0]  ch_sel;
    logic [2:0]  mode;
    logic        start_flag;
    logic        ext_sel;
    logic [1:0]  div_sel;
    logic        sh_en;
    logic        res10;
    logic [1:0]  sweep_sel;
    logic [SAC_IRQ_W-1:0] irq_status;
    logic [SAC_IRQ_W-1:0] irq_mask;
    logic        pend;
    logic        trig_q;
    logic [1:0]  div_cnt;
    logic [5:0]  cyc;
    logic [5:0]  conv_total;
    logic        conv_res10;
    logic [2:0]  cur_ch;
    logic        on_emph;
    logic [2:0]  emph_next;
    logic [2:0]  other_next;
    logic [SAC_RES_W-1:0] mem_rdata;

    // APB decode
    logic        acc;
    logic        wr_fire;
    logic        rd_fire;
    logic        in_res;
    logic [11:0] res_off;
    logic        mapped;
    assign acc     = psel_i & penable_i;
    assign wr_fire = acc & pready_o & pwrite_i;
    assign rd_fire = acc & pready_o & ~pwrite_i;
    assign in_res  = (paddr_i >= SAC_OFF_RES_LO) && (paddr_i < SAC_OFF_RES_END);
    assign res_off = paddr_i - SAC_OFF_RES_LO;
    assign mapped  = in_res || paddr_i == SAC_OFF_CTRL0 || paddr_i == SAC_OFF_CTRL1
                  || paddr_i == SAC_OFF_IRQ_STAT || paddr_i == SAC_OFF_IRQ_MASK
                  || paddr_i == SAC_OFF_STATE;

    logic wr_ctrl0;
    logic wr_start1;
    logic wr_start0;
    assign wr_ctrl0  = wr_fire && paddr_i == SAC_OFF_CTRL0;
    assign wr_start1 = wr_ctrl0 && pwdata_i[SAC_START_BIT];
    assign wr_start0 = wr_ctrl0 && !pwdata_i[SAC_START_BIT];

    // Triggers
    logic ext_fall;
    logic go;
    assign ext_fall = trig_q & ~external_trigger_input_i;
    // A start write that also selects the external trigger only arms
    assign go = (ext_sel & start_flag & ext_fall)
              | (wr_start1 & ~pwdata_i[SAC_EXT_BIT] & ~start_flag);

    // Conversion clock enable
    logic tick;
    always_comb begin
        unique case (div_sel)
            SAC_DIV_1: tick = 1'b1;
            SAC_DIV_2: tick = div_cnt[0];
            default:   tick = div_cnt == 2'h3;
        endcase
    end

    // Conversion length and trial window
    logic [5:0] cur_total;
    logic [5:0] trial_start;
    logic [3:0] bit_idx;
    assign cur_total = sh_en ? (res10 ? SAC_CYC_SH_10 : SAC_CYC_SH_8)
                             : (res10 ? SAC_CYC_10 : SAC_CYC_8);
    assign trial_start = conv_total - (conv_res10 ? SAC_BITS_10 : SAC_BITS_8);
    assign bit_idx = 4'(6'd9 - (cyc - trial_start));

    // Approximation step
    logic [9:0] next_sar;
    logic       in_trial;
    logic       last_tick;
    assign in_trial  = state == SAC_CONV && cyc >= trial_start;
    assign last_tick = state == SAC_CONV && tick && cyc == conv_total - 6'd1;
    always_comb begin
        next_sar = sar_code_o;
        if (cyc == trial_start - 6'd1) begin
            next_sar = 10'h200;
        end else if (in_trial) begin
            if (!comp_i) begin
                next_sar[bit_idx] = 1'b0;
            end
            if (bit_idx != 4'(10 - (conv_res10 ? 10 : 8))) begin
                next_sar[bit_idx - 4'd1] = 1'b1;
            end
        end
    end

    logic [SAC_RES_W-1:0] result;
    assign result = conv_res10 ? next_sar : {2'h0, next_sar[9:2]};

    // Channel sequencing
    logic [2:0] nsweep;
    logic [2:0] first_ch;
    logic [2:0] next_ch;
    logic       seq_end;
    logic [2:0] go_mode;
    logic [2:0] go_ch;
    // Start write takes mode and channel from the bus, registers lag one edge
    assign go_mode  = wr_ctrl0 ? pwdata_i[SAC_MODE_LSB +: 3] : mode;
    assign go_ch    = wr_ctrl0 ? pwdata_i[SAC_CH_LSB +: 3] : ch_sel;
    assign nsweep = (go_mode == SAC_MODE_RSWEEP1) ? 3'(sweep_sel) : 3'({sweep_sel, 1'b1});
    assign first_ch = (go_mode == SAC_MODE_ONESHOT || go_mode == SAC_MODE_REPEAT) ? go_ch : 3'h0;
    always_comb begin
        next_ch = cur_ch;
        seq_end = 1'b0;
        unique case (mode)
            SAC_MODE_ONESHOT: seq_end = 1'b1;
            SAC_MODE_SWEEP: begin
                seq_end = cur_ch == nsweep;
                next_ch = cur_ch + 3'h1;
            end
            SAC_MODE_RSWEEP0: next_ch = (cur_ch == nsweep) ? 3'h0 : cur_ch + 3'h1;
            SAC_MODE_RSWEEP1: next_ch = on_emph ? other_next : emph_next;
            default: next_ch = cur_ch;
        endcase
    end

    // Control FSM
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state      <= SAC_IDLE;
            cyc        <= '0;
            cur_ch     <= '0;
            conv_total <= SAC_CYC_8;
            conv_res10 <= 1'b0;
        end else if (wr_start0) begin
            state <= SAC_IDLE;
        end else if (go) begin
            state      <= SAC_CONV;
            cyc        <= '0;
            cur_ch     <= first_ch;
            conv_total <= cur_total;
            conv_res10 <= res10;
        end else if (state == SAC_CONV && tick) begin
            cyc <= cyc + 6'd1;
            if (last_tick) begin
                cyc    <= '0;
                cur_ch <= next_ch;
                if (seq_end) begin
                    state <= SAC_IDLE;
                end
            end
        end
    end

    // Repeat sweep 1 alternation: emphasised pins interleave with the rest
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            on_emph    <= 1'b1;
            emph_next  <= '0;
            other_next <= '0;
        end else if (go) begin
            on_emph    <= 1'b1;
            emph_next  <= (nsweep == 3'h0) ? 3'h0 : 3'h1;
            other_next <= nsweep + 3'h1;
        end else if (last_tick && mode == SAC_MODE_RSWEEP1) begin
            on_emph <= ~on_emph;
            if (on_emph) begin
                other_next <= (other_next == 3'(NCH - 1)) ? nsweep + 3'h1 : other_next + 3'h1;
            end else begin
                emph_next <= (emph_next == nsweep) ? 3'h0 : emph_next + 3'h1;
            end
        end
    end

    // Divider and approximation register
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            div_cnt    <= '0;
            sar_code_o <= '0;
        end else begin
            div_cnt <= (go || tick) ? 2'h0 : div_cnt + 2'h1;
            if (go) begin
                sar_code_o <= '0;
            end else if (state == SAC_CONV && tick) begin
                sar_code_o <= next_sar;
            end
        end
    end

    // Control registers; software write wins over the hardware clear
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ch_sel         <= '0;
            mode           <= SAC_MODE_ONESHOT;
            start_flag     <= 1'b0;
            ext_sel        <= 1'b0;
            div_sel        <= SAC_DIV_1;
            sh_en          <= 1'b0;
            res10          <= 1'b0;
            sweep_sel      <= '0;
            vref_connect_o <= 1'b0;
            irq_mask       <= '0;
        end else begin
            if (last_tick && seq_end && !ext_sel) begin
                start_flag <= 1'b0;
            end
            if (wr_ctrl0) begin
                ch_sel     <= pwdata_i[SAC_CH_LSB +: 3];
                mode       <= pwdata_i[SAC_MODE_LSB +: 3];
                start_flag <= pwdata_i[SAC_START_BIT];
                ext_sel    <= pwdata_i[SAC_EXT_BIT];
                div_sel    <= pwdata_i[SAC_DIV_LSB +: 2];
            end
            if (wr_fire && paddr_i == SAC_OFF_CTRL1) begin
                sh_en          <= pwdata_i[SAC_SH_BIT];
                res10          <= pwdata_i[SAC_RES10_BIT];
                sweep_sel      <= pwdata_i[SAC_SWEEP_LSB +: 2];
                vref_connect_o <= pwdata_i[SAC_VREF_BIT];
            end
            if (wr_fire && paddr_i == SAC_OFF_IRQ_MASK) begin
                irq_mask <= pwdata_i[SAC_IRQ_W-1:0];
            end
        end
    end

    // Interrupt status: read clears, a new event in the same cycle survives
    logic [SAC_IRQ_W-1:0] irq_set;
    logic [SAC_IRQ_W-1:0] next_irq_status;
    assign irq_set[SAC_IRQ_ONESHOT] = last_tick && !wr_start0 && !go
                                      && mode == SAC_MODE_ONESHOT;
    assign irq_set[SAC_IRQ_SWEEP]   = last_tick && !wr_start0 && !go
                                      && mode == SAC_MODE_SWEEP && seq_end;
    assign next_irq_status = ((rd_fire && paddr_i == SAC_OFF_IRQ_STAT) ? '0 : irq_status)
                           | irq_set;
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            irq_status <= '0;
            irq_o      <= 1'b0;
            trig_q     <= 1'b1;
        end else begin
            irq_status <= next_irq_status;
            irq_o      <= |(next_irq_status & irq_mask);
            trig_q     <= external_trigger_input_i;
        end
    end

    // Pin-side outputs
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            analog_channels_o <= '0;
            sample_o          <= 1'b0;
            busy_o            <= 1'b0;
        end else begin
            analog_channels_o <= go ? first_ch : (last_tick ? next_ch : cur_ch);
            sample_o          <= state == SAC_CONV && !wr_start0 && cyc < trial_start;
            busy_o            <= (state == SAC_CONV || go) && !wr_start0
                                 && !(last_tick && seq_end);
        end
    end

    // Result store; an abort in the final cycle discards the value
    sac_result_mem #(
        .DEPTH (NCH),
        .WIDTH (SAC_RES_W),
        .LO_W  (SAC_LO_W),
        .AW    (3)
    ) u_mem (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .we_lo_i (last_tick && !wr_start0 && !go),
        .we_hi_i (last_tick && !wr_start0 && !go && conv_res10),
        .waddr_i (cur_ch),
        .wdata_i (result),
        .raddr_i (res_off[SAC_RES_CH_LSB +: 3]),
        .rdata_o (mem_rdata)
    );

    // APB read mux; every access takes two wait states, which also cover the memory read
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (in_res) begin
            rd_mux = res_off[SAC_RES_HI_BIT] ? 32'(mem_rdata[SAC_RES_W-1:SAC_LO_W])
                                             : 32'(mem_rdata[SAC_LO_W-1:0]);
        end else if (paddr_i == SAC_OFF_CTRL0) begin
            rd_mux = 32'({div_sel, ext_sel, start_flag, mode, ch_sel});
        end else if (paddr_i == SAC_OFF_CTRL1) begin
            rd_mux = 32'({vref_connect_o, 2'h0, sweep_sel, res10, sh_en});
        end else if (paddr_i == SAC_OFF_IRQ_STAT) begin
            rd_mux = 32'(irq_status);
        end else if (paddr_i == SAC_OFF_IRQ_MASK) begin
            rd_mux = 32'(irq_mask);
        end else if (paddr_i == SAC_OFF_STATE) begin
            rd_mux = 32'({sample_o, cur_ch, busy_o});
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pend      <= 1'b0;
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o  <= '0;
        end else begin
            pready_o  <= acc && pend && !pready_o;
            pslverr_o <= acc && pend && !pready_o && !mapped;
            if (pready_o) begin
                pend <= 1'b0;
            end else if (acc) begin
                pend <= 1'b1;
            end
            if (acc && pend && !pready_o) begin
                prdata_o <= mapped ? rd_mux : 32'h0000_0000;
            end
        end
    end
endmodule
`default_nettype wire

/* File: sac_assertions.sv */
// Checker of the converter control block, bound to its top module
`default_nettype none
module sac_assertions
    import sac_pkg::*;
(
    // Clock and reset
    input wire logic        clk_i,
    input wire logic        rst_n_i,
    // APB
    input wire logic        psel_i,
    input wire logic        penable_i,
    input wire logic        pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic        pready_o,
    input wire logic        pslverr_o,
    // Interrupt and front end
    input wire logic        irq_o,
    input wire logic        external_trigger_input_i,
    input wire logic [2:0]  analog_channels_o,
    input wire logic        sample_o,
    input wire logic        busy_o,
    input wire logic        vref_connect_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    logic       wr_c0;
    logic       wr_c1;
    logic       osh;
    logic       msk;
    logic [9:0] c0;
    logic [1:0] c1;
    logic [9:0] cnt;
    logic [9:0] base;
    logic [9:0] dv;
    logic [9:0] len;
    assign wr_c0 = psel_i && penable_i && pready_o && pwrite_i && paddr_i == SAC_OFF_CTRL0;
    assign wr_c1 = psel_i && penable_i && pready_o && pwrite_i && paddr_i == SAC_OFF_CTRL1;
    assign osh = c0[5:3] == SAC_MODE_ONESHOT && !c0[SAC_EXT_BIT];
    assign base = c1[1] ? (c1[0] ? 10'(SAC_CYC_SH_10) : 10'(SAC_CYC_10))
                        : (c1[0] ? 10'(SAC_CYC_SH_8) : 10'(SAC_CYC_8));
    assign dv = (c0[9:8] == SAC_DIV_1) ? 10'h001 : (c0[9:8] == SAC_DIV_2) ? 10'h002 : 10'h004;
    assign len = 10'(base * dv);
    // Shadow of software settings, so timing can be judged from the ports alone
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            c0 <= '0;
            c1 <= '0;
            msk <= 1'b0;
        end else begin
            if (wr_c0) c0 <= pwdata_i[9:0];
            if (wr_c1) c1 <= {pwdata_i[SAC_RES10_BIT], pwdata_i[SAC_SH_BIT]};
            if (pready_o && pwrite_i && paddr_i == SAC_OFF_IRQ_MASK) msk <= pwdata_i[0];
        end
    end
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) cnt <= '0;
        else cnt <= busy_o ? cnt + 10'h001 : 10'h000;
    end
    a_busy_len: assert property ($fell(busy_o) && osh && !$past(wr_c0)
        |-> cnt + dv > len && cnt < len + dv) else $error("conversion length wrong");
    a_irq_oneshot: assert property ($fell(busy_o) && osh && !$past(wr_c0) && msk
        |=> irq_o) else $error("no interrupt after one-shot");
    a_irq_rise_cause: assert property ($rose(irq_o) |->
        $fell(busy_o) || $past(pready_o && pwrite_i, 2))
        else $error("interrupt without cause");
    a_abort_stops: assert property (wr_c0 && busy_o && !pwdata_i[SAC_START_BIT]
        |=> !busy_o ##1 !$rose(irq_o)) else $error("abort did not stop cleanly");
    a_vref_follow: assert property (wr_c1 |=>
        vref_connect_o == $past(pwdata_i[SAC_VREF_BIT])) else $error("ladder bit wrong");
    a_chan_hold: assert property (busy_o && osh |-> analog_channels_o == c0[2:0])
        else $error("wrong channel converted");
    a_start_cause: assert property ($rose(busy_o) |->
        $past(wr_c0 && pwdata_i[SAC_START_BIT])
        || ($past(!external_trigger_input_i) && $past(external_trigger_input_i, 2)))
        else $error("conversion started without trigger");
    a_sample_busy: assert property (sample_o |-> busy_o)
        else $error("sampling outside conversion");
    a_result_mapped: assert property (pready_o && paddr_i >= SAC_OFF_RES_LO
        && paddr_i < SAC_OFF_RES_END |-> !pslverr_o) else $error("result not mapped");
    a_ready_pulse: assert property (pready_o |=> !pready_o)
        else $error("ready longer than one cycle");
endmodule
bind sac_top sac_assertions chk_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .irq_o(irq_o),
    .external_trigger_input_i(external_trigger_input_i),
    .analog_channels_o(analog_channels_o), .sample_o(sample_o), .busy_o(busy_o),
    .vref_connect_o(vref_connect_o));
`default_nettype wire

/* File: sac_analog_model.sv */
// Behavioural analog front end: channel levels, reference ladder, comparator
`default_nettype none
module sac_analog_model (
    // Clock
    input  wire logic       clk_i,
    // From the converter
    input  wire logic [2:0] ch_i,
    input  wire logic [9:0] code_i,
    input  wire logic       vref_i,
    // Comparator decision
    output logic            comp_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic       junk = 1'b0;
    logic [9:0] vin;
    // Detached ladder gives noise, never a clean answer
    always @(posedge clk_i) junk <= ~junk;
    assign vin = 10'(ch_i) * 10'h080 + 10'h035;
    assign comp_o = vref_i ? (vin >= code_i) : junk;
endmodule
`default_nettype wire

/* File: sac_testbench.sv */
// Self-checking testbench of the converter control block
`default_nettype none
module testbench
    import sac_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [5:0] c1;
        logic [1:0] dv;
        logic [2:0] ch;
        logic [9:0] len;
        logic [9:0] tol;
    } sac_row_t;
    localparam sac_row_t ROWS [4] = '{'{6'h20, 2'h0, 3'h3, 10'h031, 10'h000},
        '{6'h22, 2'h0, 3'h7, 10'h03B, 10'h000}, '{6'h21, 2'h1, 3'h0, 10'h038, 10'h001},
        '{6'h23, 2'h2, 3'h5, 10'h084, 10'h003}};
    logic        clk_i, rst_n_i, psel_i, penable_i, pwrite_i, ext_i, comp_i;
    logic [11:0] paddr_i;
    logic [31:0] pwdata_i, prdata_o;
    logic        pready_o, pslverr_o, irq_o, sample_o, busy_o, vref_connect_o;
    logic [2:0]  analog_channels_o;
    logic [9:0]  sar_code_o;
    int          bad_count = 0;
    int          tests_run = 0;
    sac_top dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i), .penable_i(penable_i),
        .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
        .pready_o(pready_o), .pslverr_o(pslverr_o), .irq_o(irq_o),
        .external_trigger_input_i(ext_i), .comp_i(comp_i),
        .analog_channels_o(analog_channels_o), .sar_code_o(sar_code_o),
        .sample_o(sample_o), .busy_o(busy_o), .vref_connect_o(vref_connect_o));
    sac_analog_model am_u (.clk_i(clk_i), .ch_i(analog_channels_o), .code_i(sar_code_o),
        .vref_i(vref_connect_o), .comp_o(comp_i));
    task automatic wrap_up();
        $display("Checks run %0d, mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask
    // Request held until pready is seen high at an edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        int n;
        @(posedge clk_i);
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (pready_o !== 1'b1 && n < 50);
        if (n == 50) chk("pready", 32'h1, 32'(pready_o));
        r = prdata_o;
        e = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
    endtask
    task automatic rd(input string what, input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0, r, e);
        chk(what, exp, r);
    endtask
    task automatic run_len(output int n);
        n = 0;
        do begin
            @(posedge clk_i);
            if (busy_o === 1'b1) n++;
        end while (busy_o === 1'b1 && n < 2000);
    endtask
    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end
    initial begin
        repeat (20000) @(posedge clk_i);
        bad_count++;
        wrap_up();
    end
    initial begin
        int          n;
        logic [9:0]  v;
        logic [11:0] a;
        logic [31:0] r;
        logic        e;
        {rst_n_i, psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} = '0;
        ext_i = 1'b1;
        repeat (3) @(posedge clk_i);
        rst_n_i <= 1'b1;
        for (int i = 0; i < 5; i++) rd("reset value", 12'(i * 4), 32'h0);
        chk("ladder at reset", 32'h0, 32'(vref_connect_o));
        wr(SAC_OFF_IRQ_MASK, 32'h3);
        for (int i = 0; i < 4; i++) begin
            wr(SAC_OFF_CTRL1, 32'(ROWS[i].c1));
            wr(SAC_OFF_CTRL0, {22'h0, ROWS[i].dv, 5'h08, ROWS[i].ch});
            run_len(n);
            chk("length", 32'h1, 32'(n + ROWS[i].tol >= ROWS[i].len
                && n <= ROWS[i].len + ROWS[i].tol));
            rd("start cleared", SAC_OFF_CTRL0, {22'h0, ROWS[i].dv, 5'h00, ROWS[i].ch});
            chk("irq level", 32'h1, 32'(irq_o));
            v = 10'(ROWS[i].ch) * 10'h080 + 10'h035;
            a = SAC_OFF_RES_LO + 12'(ROWS[i].ch) * 12'h008;
            rd("low part", a, ROWS[i].c1[1] ? 32'(v[7:0]) : 32'(v[9:2]));
            rd("high part", a + 12'h004, ROWS[i].c1[1] ? 32'(v[9:8]) : 32'h0);
            rd("status", SAC_OFF_IRQ_STAT, 32'h1);
            rd("status cleared", SAC_OFF_IRQ_STAT, 32'h0);
            @(posedge clk_i);
            chk("irq cleared", 32'h0, 32'(irq_o));
        end
        wr(SAC_OFF_CTRL0, 32'h042);
        repeat (10) @(posedge clk_i);
        wr(SAC_OFF_CTRL0, 32'h002);
        run_len(n);
        chk("busy after stop", 32'h0, 32'(n));
        rd("result kept", SAC_OFF_RES_LO + 12'h010, 32'h0);
        rd("no status on abort", SAC_OFF_IRQ_STAT, 32'h0);
        wr(SAC_OFF_CTRL1, 32'h20);
        wr(SAC_OFF_CTRL0, 32'h0C1);
        repeat (5) @(posedge clk_i);
        chk("armed only", 32'h0, 32'(busy_o));
        ext_i <= 1'b0;
        repeat (20) @(posedge clk_i);
        ext_i <= 1'b1;
        @(posedge clk_i);
        ext_i <= 1'b0;
        run_len(n);
        chk("retrigger", 32'h1, 32'(n >= 49 && n <= 51));
        rd("start kept", SAC_OFF_CTRL0, 32'h0C1);
        rd("ext status", SAC_OFF_IRQ_STAT, 32'h1);
        wr(SAC_OFF_CTRL0, 32'h0);
        for (int m = 1; m < 5; m++) begin
            wr(SAC_OFF_CTRL0, 32'(m * 8 + 64));
            repeat (200) @(posedge clk_i);
            chk("mode busy", 32'(m != 2), 32'(busy_o));
            wr(SAC_OFF_CTRL0, 32'h0);
            rd("mode status", SAC_OFF_IRQ_STAT, (m == 2) ? 32'h2 : 32'h0);
        end
        apb(1'b0, SAC_OFF_RES_END, 32'h0, r, e);
        chk("unmapped error", 32'h1, 32'(e));
        chk("unmapped data", 32'h0, r);
        wrap_up();
    end
endmodule
`default_nettype wire
